// [core/sdl_latch.sv]
`timescale 1ns/10ps
// Operation
// RL1: Low frame select bounds one transfer
// RL2: Sample data on each rising serial clock
// RL3: Sixteen bits form one 16-bit code
// RL4: Low latch update copies input to converter
// RL5: First bit lands in bit 15
// RL6: Frame rise after sixteen bits transfers word
// RL7: Clock edges ignored while frame high
// RL8: Host holds latch high during shifting; held low, the frame rise updates the converter at once
// RL9: Converter holds zero until first word
module sdl_latch
   import sdl_pkg::*;
#(
   parameter int WORD_BITS = SDL_WORD_BITS
)(
   input  wire logic                 clk_sys,
   input  wire logic                 rst,
   input  wire logic                 frame_n,
   input  wire logic                 sclk,
   input  wire logic                 sdata,
   input  wire logic                 latch_update_n,
   output logic [WORD_BITS-1:0]      dac_code,
   output logic [WORD_BITS-1:0]      input_word,
   output logic                      word_loaded
);
   // ---------------------------------------------------------------
   // Pin synchronisation
   // ---------------------------------------------------------------
   // Every pin passes two flops before any logic reads it, so a pin
   // change is acted on at the third clock edge after it
   sdl_pins_t pins_raw;      // Raw pins as a bundle
   sdl_pins_t pins;          // Synchronised pins

   // Bundle the raw pins for the synchroniser
   assign pins_raw = '{frame_n: frame_n, sclk: sclk, sdata: sdata,
                       latch_update_n: latch_update_n};

   sdl_sync u_sync (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .pins_in  (pins_raw),
      .pins_out (pins)
   );

   // ---------------------------------------------------------------
   // Edge detection state
   // ---------------------------------------------------------------
   // Delayed copies of the synchronised pins find the edges
   logic sclk_d;             // Previous serial clock
   logic frame_d;            // Previous frame select
   logic sclk_rise;          // Serial clock rising
   logic frame_rise;         // Frame select end

   // Edge decode; the delayed copies reset to the idle pin levels,
   // so leaving reset never shows a false edge
   always_comb begin
      sclk_rise  = pins.sclk & ~sclk_d;
      frame_rise = pins.frame_n & ~frame_d;
   end

   // ---------------------------------------------------------------
   // Shift and transfer state
   // ---------------------------------------------------------------
   // The pending flag lets a word wait between frame end and latch
   logic [WORD_BITS-1:0] shift_reg;      // Input shift register
   logic [WORD_BITS-1:0] next_shift_reg;
   logic [4:0]           bit_cnt;        // Bits seen this frame
   logic [4:0]           next_bit_cnt;
   logic [WORD_BITS-1:0] in_reg;         // Input register
   logic [WORD_BITS-1:0] next_in_reg;
   logic                 pend;           // Word waits for latch
   logic                 next_pend;
   logic [WORD_BITS-1:0] code;           // Converter register
   logic [WORD_BITS-1:0] next_code;
   logic                 loaded;         // Converter just updated
   logic                 next_loaded;

   // Next-state computation: shifting, frame close and
   // converter update for one clock
   always_comb begin
      next_shift_reg = shift_reg;
      next_bit_cnt   = bit_cnt;
      next_in_reg    = in_reg;
      next_pend      = pend;
      next_code      = code;
      next_loaded    = 1'b0;
      if (!pins.frame_n) begin
         // Shift only inside a frame
         if (sclk_rise) begin // RL7
            // MSB first into the low end
            next_shift_reg = {shift_reg[WORD_BITS-2:0],
                              pins.sdata}; // RL2 RL5
            // Count stops at sixteen: extra bits keep the last sixteen
            if (bit_cnt != SDL_FULL_CNT) begin
               next_bit_cnt = bit_cnt + 5'h01; // RL3
            end
         end
      end else if (frame_rise) begin
         // Frame closed: new frame starts count afresh
         next_bit_cnt = SDL_BIT_CNT_RST; // RL1
         // Short frames are dropped whole
         if (bit_cnt == SDL_FULL_CNT) begin
            next_in_reg = shift_reg; // RL6
            next_pend   = 1'b1;      // Word waits for latch
         end
      end
      // Latch low copies input register whole; while held low the
      // frame rise updates the converter at once
      if (!pins.latch_update_n && (next_pend || pend)) begin
         next_code   = next_pend ? next_in_reg : in_reg; // RL4 RL8
         next_pend   = 1'b0;
         next_loaded = 1'b1;
      end
   end

   // State registers
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sclk_d    <= SDL_PINS_IDLE.sclk;
         frame_d   <= SDL_PINS_IDLE.frame_n;
         shift_reg <= SDL_CODE_RST;
         bit_cnt   <= SDL_BIT_CNT_RST;
         in_reg    <= SDL_CODE_RST;
         pend      <= 1'b0;
         code      <= SDL_CODE_RST; // RL9
         loaded    <= 1'b0;
      end else begin
         // Edge finders follow the synchronised pins
         sclk_d    <= pins.sclk;
         frame_d   <= pins.frame_n;
         shift_reg <= next_shift_reg;
         bit_cnt   <= next_bit_cnt;
         in_reg    <= next_in_reg;
         pend      <= next_pend;
         code      <= next_code;
         loaded    <= next_loaded;
      end
   end

   // Outputs come straight from registers
   assign dac_code    = code;
   assign input_word  = in_reg;
   assign word_loaded = loaded;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   // Sixteen bits seen when the frame closes
   sequence s_full_close;
      frame_rise && bit_cnt == SDL_FULL_CNT;
   endsequence

   // Full frame closes while the latch pin stays high
   sequence s_held_close;
      s_full_close ##0 pins.latch_update_n;
   endsequence

   // Latch low with a word waiting and no new word arriving
   sequence s_latched;
      pend && !pins.latch_update_n
         && !(frame_rise && bit_cnt == SDL_FULL_CNT);
   endsequence

   // Shift path
   shift_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
      pins.frame_n |=> shift_reg == $past(shift_reg)) // RL7
      else $error("shift moved with frame high");
   shift_in_a: assert property (@(posedge clk_sys) disable iff (rst)
      (!pins.frame_n && sclk_rise) |=>
      shift_reg[0] == $past(pins.sdata)) // RL2
      else $error("data bit not sampled");
   msb_first_a: assert property (@(posedge clk_sys) disable iff (rst)
      (!pins.frame_n && sclk_rise) |=>
      shift_reg[WORD_BITS-1:1] == $past(shift_reg[WORD_BITS-2:0])) // RL5
      else $error("shift order wrong");
   count_cap_a: assert property (@(posedge clk_sys) disable iff (rst)
      bit_cnt <= SDL_FULL_CNT) // RL3
      else $error("bit count overran");
   count_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
      (pins.frame_n && !frame_rise) |=> bit_cnt == $past(bit_cnt)) // RL7
      else $error("count moved with frame high");

   // Frame close
   frame_xfer_a: assert property (@(posedge clk_sys) disable iff (rst)
      s_full_close |=> in_reg == $past(shift_reg)) // RL6
      else $error("input register not loaded");
   frame_reset_a: assert property (@(posedge clk_sys) disable iff (rst)
      frame_rise |=> bit_cnt == SDL_BIT_CNT_RST) // RL1
      else $error("count not cleared at frame end");
   short_drop_a: assert property (@(posedge clk_sys) disable iff (rst)
      !(frame_rise && bit_cnt == SDL_FULL_CNT) |=>
      in_reg == $past(in_reg)) // RL3
      else $error("input register changed without full frame");
   defer_pend_a: assert property (@(posedge clk_sys) disable iff (rst)
      s_held_close |=> pend && code == $past(code)) // RL6
      else $error("word not held for latch");

   // Converter update
   latch_copy_a: assert property (@(posedge clk_sys) disable iff (rst)
      s_latched |=> code == $past(in_reg) && word_loaded) // RL4
      else $error("latch did not update converter");
   tied_low_a: assert property (@(posedge clk_sys) disable iff (rst)
      (s_full_close and !pins.latch_update_n) |=>
      code == $past(shift_reg)) // RL8
      else $error("tied-low update missed");
   whole_copy_a: assert property (@(posedge clk_sys) disable iff (rst)
      loaded |-> code == in_reg) // RL4
      else $error("converter differs from input register");
   loaded_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
      loaded |=> !loaded) // RL4
      else $error("update pulse longer than one cycle");
   no_pend_a: assert property (@(posedge clk_sys) disable iff (rst)
      (!pend && !frame_rise) |=> !loaded) // RL4
      else $error("update without a waiting word");
   code_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
      !loaded |-> code == $past(code)) // RL4
      else $error("converter changed without update");

   // Power-up value
   hold_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
      !loaded && $past(code) == SDL_CODE_RST |-> code == SDL_CODE_RST) // RL9
      else $error("converter changed without load");
endmodule // sdl_latch

// [core/sdl_pkg.sv]
package sdl_pkg;
   // ---------------------------------------------------------------
   // Word format
   // ---------------------------------------------------------------
   localparam int          SDL_WORD_BITS  = 16;    // Bits per frame
   localparam logic [4:0]  SDL_BIT_CNT_RST = 5'h00; // Count after reset
   localparam logic [15:0] SDL_CODE_RST   = 16'h0000; // Converter at reset
   localparam logic [4:0]  SDL_FULL_CNT   = 5'h10; // Sixteen bits seen
   // ---------------------------------------------------------------
   // Pin sampling
   // ---------------------------------------------------------------
   localparam int          SDL_SYNC_DEPTH = 2;     // Synchroniser stages

   // Synchronised serial pins
   typedef struct packed {
      logic frame_n;        // Frame select, low active
      logic sclk;           // Serial clock
      logic sdata;          // Serial data
      logic latch_update_n; // Latch update, low active
   } sdl_pins_t;

   // Pin levels while idle; also the synchroniser reset value
   localparam sdl_pins_t SDL_PINS_IDLE = '{frame_n: 1'b1, sclk: 1'b0,
                                          sdata: 1'b0,
                                          latch_update_n: 1'b1};
endpackage

// [core/sdl_sync.sv]
`timescale 1ns/10ps
// ------------------------------------------------------------------
// Two-flop synchroniser for a bundle of pins
// ------------------------------------------------------------------
module sdl_sync
   import sdl_pkg::*;
(
   input  wire logic      clk_sys,
   input  wire logic      rst,
   input  wire sdl_pins_t pins_in,
   output sdl_pins_t      pins_out
);
   sdl_pins_t stage1;        // First stage, read only by second
   sdl_pins_t stage2;        // Second stage

   // Reset to idle levels: frame and latch high
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         stage1 <= SDL_PINS_IDLE;
         stage2 <= SDL_PINS_IDLE;
      end else begin
         stage1 <= pins_in;
         stage2 <= stage1;
      end
   end

   assign pins_out = stage2;
endmodule // sdl_sync

// [test/sdl_host.sv]
`timescale 1ns/10ps
// ------------------------------------------------------------------
// Host model: frame select, serial clock, data, latch update
// ------------------------------------------------------------------
module sdl_host (
   input  wire logic clk_sys,        // Bench clock
   output logic      frame_n,        // Frame select, low active
   output logic      sclk,           // Serial clock, 160 ns period
   output logic      sdata,          // Serial data
   output logic      latch_update_n  // Latch update, low active
);
   // Idle pins at time zero
   initial begin
      frame_n        = 1'b1;
      sclk           = 1'b0;
      sdata          = 1'b0;
      latch_update_n = 1'b1;
   end

   // One frame of n bits, first bit taken from bit 15
   task automatic send_bits(input logic [15:0] w, input int n);
      @(posedge clk_sys);
      frame_n <= 1'b0;
      for (int i = 0; i < n; i++) begin
         sdata <= w[15-i];
         repeat (4) @(posedge clk_sys);
         sclk <= 1'b1;
         repeat (4) @(posedge clk_sys);
         sclk <= 1'b0;
      end
      repeat (4) @(posedge clk_sys);
      frame_n <= 1'b1;
      sdata   <= ~sdata;              // Released line shows no old bit
      repeat (4) @(posedge clk_sys);
   endtask

   // Low pulse on the latch after the frame has closed
   task automatic pulse_latch();
      repeat (4) @(posedge clk_sys);
      latch_update_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      latch_update_n <= 1'b1;
   endtask

   // Hold the latch at a level, low means update at frame end
   task automatic set_latch(input logic v);
      @(posedge clk_sys);
      latch_update_n <= v;
   endtask

   // Clock and data toggling with the frame left high
   task automatic stray_clocks(input int n);
      for (int i = 0; i < n; i++) begin
         sdata <= ~sdata;
         repeat (4) @(posedge clk_sys);
         sclk <= ~sclk;
      end
   endtask
endmodule // sdl_host

// [test/tb_top.sv]
`timescale 1ns/10ps
// ------------------------------------------------------------------
// Bench for the serial input latch
// ------------------------------------------------------------------
module tb_top
   import sdl_pkg::*;
;
   logic        clk_sys = 1'b0; // 50 MHz clock
   logic        rst     = 1'b1; // Async reset
   logic        frame_n;        // Host pins
   logic        sclk;
   logic        sdata;
   logic        latch_update_n;
   logic [15:0] dac_code;       // Converter register
   logic [15:0] input_word;     // Input register
   logic        word_loaded;    // Update pulse
   int          mismatches = 0; // Failed compares
   int          cmp_count  = 0; // All compares
   int          loads      = 0; // Update pulses seen

   // Clock, 20 ns period
   always #10 clk_sys = ~clk_sys;

   // Count converter update pulses
   always @(posedge clk_sys) begin
      if (word_loaded === 1'b1) begin
         loads <= loads + 1;
      end
   end

   sdl_host u_sdl_host (.clk_sys(clk_sys), .frame_n(frame_n), .sclk(sclk),
      .sdata(sdata), .latch_update_n(latch_update_n));
   sdl_latch u_sdl_latch (.clk_sys(clk_sys), .rst(rst), .frame_n(frame_n),
      .sclk(sclk), .sdata(sdata), .latch_update_n(latch_update_n),
      .dac_code(dac_code), .input_word(input_word),
      .word_loaded(word_loaded));

   task automatic check16(input string nm, input logic [15:0] exp,
                          input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask

   task automatic check_cnt(input string nm, input int exp, input int got);
      cmp_count++;
      if (got != exp) begin
         mismatches++;
         $display("unexpected %s: expected %0d, seen %0d", nm, exp, got);
      end
   endtask

   task automatic settle();
      repeat (3) @(posedge clk_sys);
      #1;
   endtask

   task automatic stop_test();
      $display("mismatches %0d, compares %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic t_reset();
      settle();
      check16("dac_code", SDL_CODE_RST, dac_code);
      check16("input_word", SDL_CODE_RST, input_word);
   endtask

   task automatic t_deferred();
      int n0 = loads;
      u_sdl_host.send_bits(16'ha5c3, 16);
      settle();
      check16("input_word", 16'ha5c3, input_word);
      check16("dac_code", SDL_CODE_RST, dac_code);
      u_sdl_host.pulse_latch();
      settle();
      check16("dac_code", 16'ha5c3, dac_code);
      check_cnt("word_loaded", n0 + 1, loads);
   endtask

   task automatic t_refused();
      int n0 = loads;
      u_sdl_host.send_bits(16'h5a3c, 15);
      u_sdl_host.stray_clocks(8);
      u_sdl_host.send_bits(16'h3c5a, 8);
      u_sdl_host.pulse_latch();
      settle();
      check16("input_word", 16'ha5c3, input_word);
      check16("dac_code", 16'ha5c3, dac_code);
      check_cnt("word_loaded", n0, loads);
   endtask

   task automatic t_direct();
      int n0 = loads;
      u_sdl_host.set_latch(1'b0);
      u_sdl_host.send_bits(16'h0001, 16);
      settle();
      check16("dac_code", 16'h0001, dac_code);
      u_sdl_host.send_bits(16'h8000, 16);
      settle();
      check16("dac_code", 16'h8000, dac_code);
      check_cnt("word_loaded", n0 + 2, loads);
      u_sdl_host.set_latch(1'b1);
   endtask

   // Reset in mid run clears both registers and any waiting word
   task automatic t_mid_reset();
      int n0 = loads;
      u_sdl_host.send_bits(16'h1234, 16);
      @(posedge clk_sys);
      rst <= 1'b1;
      settle();
      check16("dac_code", SDL_CODE_RST, dac_code);
      check16("input_word", SDL_CODE_RST, input_word);
      @(posedge clk_sys);
      rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      u_sdl_host.pulse_latch();
      settle();
      check16("dac_code", SDL_CODE_RST, dac_code);
      check_cnt("word_loaded", n0, loads);
      u_sdl_host.send_bits(16'hc35a, 16);
      u_sdl_host.pulse_latch();
      settle();
      check16("dac_code", 16'hc35a, dac_code);
      check_cnt("word_loaded", n0 + 1, loads);
   endtask

   // Main sequence
   initial begin
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      t_reset();
      t_deferred();
      t_refused();
      t_direct();
      t_mid_reset();
      stop_test();
   end

   // Watchdog, about five times the expected run
   initial begin
      #100000;
      mismatches++;
      stop_test();
   end
endmodule // tb_top
